//--- logic/waveform_update_timing.sv
// Purpose: start trigger, update strobe and interval counter for the waveform generator
// Assumes: pfi pins asynchronous; buf_done and register port on clk_sys
// Notes:   monitor pins stay released until software enables them
// How it works
// - start trigger from any pin, chosen edge
// - trigger edge starts waveform generation
// - trigger also starts interval counter if internal
// - trigger monitor: high pulse, 50-100 ns
// - monitor pins released until enabled
// - latch strobe from any pin updates converters
// - strobes act only in posted-update mode
// - strobe monitor: delivered pulse, low, 300-350 ns
// - pin strobe updates converters within 120 ns
// - interval counter makes strobes unless external
// - counter starts on trigger, stops command/buffer
// - software gate suppresses every converter update
// - interval clock from pin, edge detected
// - internal 20 MHz or 100 kHz timebase
`timescale 1ns/1ps
module waveform_update_timing (
    input  wire logic                                    clk_sys,
    input  wire logic                                    nrst,
    input  wire logic                                    ce,
    input  wire logic [wave_timing_pkg::PFI_N-1:0]       pfi_in,
    input  wire logic                                    buf_done,
    input  wire logic [wave_timing_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [wave_timing_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                                    reg_wr,
    input  wire logic                                    reg_rd,
    output logic      [wave_timing_pkg::DATA_W-1:0]      reg_rdata,
    output logic                                         wave_start,
    output logic                                         wave_running,
    output logic                                         dac_update,
    output wave_timing_pkg::pin_drive_s                  trig_mon,
    output wave_timing_pkg::pin_drive_s                  update_mon_n
);

    logic [wave_timing_pkg::PFI_N-1:0]  pfi_s;
    logic [5:0]                         trig_cfg;
    logic [5:0]                         upd_cfg;
    logic [6:0]                         clk_cfg;
    logic [wave_timing_pkg::CNT_W-1:0]  interval;
    logic [3:0]                         ctrl;
    logic [2:0]                         sel_chg;

    logic                               sw_stop;
    logic                               sw_start;

    logic                               trig_lvl;
    logic                               trig_prev;
    logic                               trig_edge;
    logic                               upd_lvl;
    logic                               upd_prev;
    logic                               upd_edge;
    logic                               xclk_lvl;
    logic                               xclk_prev;
    logic                               xclk_tick;

    logic [wave_timing_pkg::ACC_W-1:0]  acc_fast;
    logic [wave_timing_pkg::ACC_W-1:0]  acc_slow;
    logic [wave_timing_pkg::ACC_W:0]    next_fast;
    logic [wave_timing_pkg::ACC_W:0]    next_slow;
    logic                               src_tick;

    logic                               start_evt;
    logic                               stop_evt;
    logic                               upd_ext;
    wave_timing_pkg::run_state_e        cnt_state;
    logic [wave_timing_pkg::CNT_W-1:0]  cnt;
    logic                               int_tick;

    logic                               upd_req;
    logic                               upd_deliver;

    logic [wave_timing_pkg::PW_W-1:0]   trig_pw;
    logic [wave_timing_pkg::PW_W-1:0]   upd_pw;
    logic [wave_timing_pkg::UCNT_W-1:0] upd_count;

    // pick one pin and optionally invert it
    function automatic logic pick(input logic [wave_timing_pkg::PFI_N-1:0] pins,
                                  input logic [wave_timing_pkg::SEL_W-1:0] sel,
                                  input logic inv);
        logic b;
        b = 1'b0;
        if (int'(sel) < wave_timing_pkg::PFI_N) begin
            b = pins[sel];
        end
        return b ^ inv;
    endfunction

    // fractional timebase step; msb is the tick
    function automatic logic [wave_timing_pkg::ACC_W:0] tb_step(input logic [wave_timing_pkg::ACC_W-1:0] acc,
                                                                input int khz);
        int sum;
        sum = int'(acc) + khz;
        if (sum >= wave_timing_pkg::CLK_KHZ) begin
            return {1'b1, wave_timing_pkg::ACC_W'(sum - wave_timing_pkg::CLK_KHZ)};
        end
        return {1'b0, wave_timing_pkg::ACC_W'(sum)};
    endfunction

    // routed edge, masked after a source change
    function automatic logic rise(input logic lvl,
                                  input logic prev,
                                  input logic chg);
        return lvl & ~prev & ~chg;
    endfunction

    // only synchronised pins reach the routing
    pin_sync #(
        .W (wave_timing_pkg::PFI_N)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .d       (pfi_in),
        .q       (pfi_s)
    );

    // routing of the three pin functions
    always_comb begin
        trig_lvl = pick(pfi_s, trig_cfg[wave_timing_pkg::SEL_LSB +: wave_timing_pkg::SEL_W],
                        trig_cfg[wave_timing_pkg::POL_BIT]);
        upd_lvl  = pick(pfi_s, upd_cfg[wave_timing_pkg::SEL_LSB +: wave_timing_pkg::SEL_W],
                        upd_cfg[wave_timing_pkg::POL_BIT]);
        xclk_lvl = pick(pfi_s, clk_cfg[wave_timing_pkg::SEL_LSB +: wave_timing_pkg::SEL_W],
                        clk_cfg[wave_timing_pkg::POL_BIT]);
    end

    // a new source selection is not an edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sel_chg <= 3'h0;
        end else if (ce) begin
            sel_chg <= 3'h0;
            if (reg_wr) begin
                sel_chg[0] <= reg_addr == wave_timing_pkg::OFF_TRIG_CFG;
                sel_chg[1] <= reg_addr == wave_timing_pkg::OFF_UPD_CFG;
                sel_chg[2] <= reg_addr == wave_timing_pkg::OFF_CLK_CFG;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trig_prev <= 1'b0;
            upd_prev  <= 1'b0;
            xclk_prev <= 1'b0;
        end else if (ce) begin
            trig_prev <= trig_lvl;
            upd_prev  <= upd_lvl;
            xclk_prev <= xclk_lvl;
        end
    end

    assign trig_edge = rise(trig_lvl, trig_prev, sel_chg[0]);
    assign upd_edge  = rise(upd_lvl, upd_prev, sel_chg[1]);
    // a new active level counts as one interval clock
    // levels shorter than a clock can be missed
    assign xclk_tick = rise(xclk_lvl, xclk_prev, sel_chg[2]);

    // internal timebases
    // 20 MHz has one clock of jitter
    assign next_fast = tb_step(acc_fast, wave_timing_pkg::TB_FAST_KHZ);
    assign next_slow = tb_step(acc_slow, wave_timing_pkg::TB_SLOW_KHZ);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            acc_fast <= '0;
            acc_slow <= '0;
        end else if (ce) begin
            acc_fast <= next_fast[wave_timing_pkg::ACC_W-1:0];
            acc_slow <= next_slow[wave_timing_pkg::ACC_W-1:0];
        end
    end

    always_comb begin
        case (clk_cfg[wave_timing_pkg::SRC_LSB +: wave_timing_pkg::SRC_W])
            wave_timing_pkg::SRC_FAST: src_tick = next_fast[wave_timing_pkg::ACC_W];
            wave_timing_pkg::SRC_SLOW: src_tick = next_slow[wave_timing_pkg::ACC_W];
            wave_timing_pkg::SRC_EXT:  src_tick = xclk_tick;
            default:                   src_tick = next_fast[wave_timing_pkg::ACC_W];
        endcase
    end

    assign upd_ext   = upd_cfg[wave_timing_pkg::EXT_BIT];
    assign start_evt = trig_edge | sw_start;
    // buffer end stops run and counter
    assign stop_evt  = sw_stop | buf_done;

    // waveform generation run flag; a start in the stop cycle wins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wave_running <= 1'b0;
            wave_start   <= 1'b0;
        end else if (ce) begin
            wave_start <= start_evt;
            if (start_evt) begin
                wave_running <= 1'b1;
            end else if (stop_evt) begin
                wave_running <= 1'b0;
            end
        end
    end

    // update interval counter
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_state <= wave_timing_pkg::ST_IDLE;
            cnt       <= '0;
            int_tick  <= 1'b0;
        end else if (ce) begin
            int_tick <= 1'b0;
            case (cnt_state)
                wave_timing_pkg::ST_IDLE: begin
                    if (start_evt && !upd_ext) begin
                        cnt_state <= wave_timing_pkg::ST_RUN;
                        cnt       <= interval;
                    end
                end
                wave_timing_pkg::ST_RUN: begin
                    if (start_evt) begin
                        cnt <= interval;
                    end else if (stop_evt || upd_ext) begin
                        cnt_state <= wave_timing_pkg::ST_IDLE;
                    end else if (src_tick) begin
                        if (cnt <= wave_timing_pkg::CNT_W'(1)) begin
                            int_tick <= 1'b1;
                            cnt      <= interval;
                        end else begin
                            cnt <= cnt - wave_timing_pkg::CNT_W'(1);
                        end
                    end
                end
                default: begin
                    cnt_state <= wave_timing_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign upd_req     = upd_ext ? upd_edge : int_tick;
    // the source keeps strobes far enough apart to reload the latches
    assign upd_deliver = upd_req & ctrl[wave_timing_pkg::CTRL_POSTED]
                         & ~ctrl[wave_timing_pkg::CTRL_GATE];

    // converter latch pulse and monitor pulse widths
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dac_update <= 1'b0;
            trig_pw    <= '0;
            upd_pw     <= '0;
            upd_count  <= '0;
        end else if (ce) begin
            dac_update <= upd_deliver;
            if (start_evt) begin
                trig_pw <= wave_timing_pkg::PW_W'(wave_timing_pkg::TRIG_PULSE_CYC);
            end else if (trig_pw != '0) begin
                trig_pw <= trig_pw - wave_timing_pkg::PW_W'(1);
            end
            // a new strobe restarts the low pulse
            if (upd_deliver) begin
                upd_pw    <= wave_timing_pkg::PW_W'(wave_timing_pkg::UPD_PULSE_CYC);
                upd_count <= upd_count + wave_timing_pkg::UCNT_W'(1);
            end else if (upd_pw != '0) begin
                upd_pw <= upd_pw - wave_timing_pkg::PW_W'(1);
            end
        end
    end

    // monitor pins: released until enabled
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trig_mon     <= '{out: 1'b0, oe: 1'b0};
            update_mon_n <= '{out: 1'b1, oe: 1'b0};
        end else if (ce) begin
            trig_mon.out     <= start_evt | (trig_pw > wave_timing_pkg::PW_W'(1));
            trig_mon.oe      <= ctrl[wave_timing_pkg::CTRL_TRIG_OE];
            update_mon_n.out <= ~(upd_deliver | (upd_pw > wave_timing_pkg::PW_W'(1)));
            update_mon_n.oe  <= ctrl[wave_timing_pkg::CTRL_UPD_OE];
        end
    end

    // register writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trig_cfg <= wave_timing_pkg::TRIG_CFG_RST;
            upd_cfg  <= wave_timing_pkg::UPD_CFG_RST;
            clk_cfg  <= wave_timing_pkg::CLK_CFG_RST;
            interval <= wave_timing_pkg::INTERVAL_RST;
            ctrl     <= wave_timing_pkg::CTRL_RST;
            sw_stop  <= 1'b0;
            sw_start <= 1'b0;
        end else if (ce) begin
            sw_stop  <= 1'b0;
            sw_start <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    wave_timing_pkg::OFF_TRIG_CFG: trig_cfg <= reg_wdata[5:0];
                    wave_timing_pkg::OFF_UPD_CFG:  upd_cfg  <= reg_wdata[5:0];
                    wave_timing_pkg::OFF_CLK_CFG:  clk_cfg  <= reg_wdata[6:0];
                    wave_timing_pkg::OFF_INTERVAL: interval <= reg_wdata[wave_timing_pkg::CNT_W-1:0];
                    wave_timing_pkg::OFF_CTRL: begin
                        ctrl     <= reg_wdata[3:0];
                        sw_stop  <= reg_wdata[wave_timing_pkg::CTRL_STOP];
                        sw_start <= reg_wdata[wave_timing_pkg::CTRL_START];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // register reads, data in the following cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    wave_timing_pkg::OFF_TRIG_CFG: reg_rdata <= {26'h0000000, trig_cfg};
                    wave_timing_pkg::OFF_UPD_CFG:  reg_rdata <= {26'h0000000, upd_cfg};
                    wave_timing_pkg::OFF_CLK_CFG:  reg_rdata <= {25'h0000000, clk_cfg};
                    wave_timing_pkg::OFF_INTERVAL: reg_rdata <= {8'h00, interval};
                    wave_timing_pkg::OFF_CTRL:     reg_rdata <= {28'h0000000, ctrl};
                    wave_timing_pkg::OFF_STATUS: begin
                        reg_rdata[wave_timing_pkg::ST_RUN_BIT]  <= wave_running;
                        reg_rdata[wave_timing_pkg::ST_CNT_BIT]  <= (cnt_state == wave_timing_pkg::ST_RUN);
                        reg_rdata[wave_timing_pkg::ST_GATE_BIT] <= ctrl[wave_timing_pkg::CTRL_GATE];
                        reg_rdata[wave_timing_pkg::ST_UCNT_LSB +: wave_timing_pkg::UCNT_W] <= upd_count;
                    end
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule

//--- logic/wave_timing_pkg.sv
// Purpose: shared constants and types for the waveform update timing block
// Assumes: 25 MHz system clock, ten programmable function inputs
// Notes:   register offsets are byte addresses on the plain register port
package wave_timing_pkg;

    localparam int PFI_N   = 10;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int CNT_W   = 24;
    localparam int ACC_W   = 16;
    localparam int UCNT_W  = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_TRIG_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_UPD_CFG  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CLK_CFG  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_INTERVAL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h14;

    // field positions
    localparam int SEL_LSB      = 0;
    localparam int SEL_W        = 4;
    localparam int POL_BIT      = 4;
    localparam int EXT_BIT      = 5;
    localparam int SRC_LSB      = 5;
    localparam int SRC_W        = 2;
    localparam int CTRL_POSTED  = 0;
    localparam int CTRL_GATE    = 1;
    localparam int CTRL_TRIG_OE = 2;
    localparam int CTRL_UPD_OE  = 3;
    localparam int CTRL_STOP    = 8;
    localparam int CTRL_START   = 9;
    localparam int ST_RUN_BIT   = 0;
    localparam int ST_CNT_BIT   = 1;
    localparam int ST_GATE_BIT  = 2;
    localparam int ST_UCNT_LSB  = 16;

    // interval clock source codes
    localparam logic [SRC_W-1:0] SRC_FAST = 2'h0;
    localparam logic [SRC_W-1:0] SRC_SLOW = 2'h1;
    localparam logic [SRC_W-1:0] SRC_EXT  = 2'h2;

    // reset values
    localparam logic [5:0]        TRIG_CFG_RST = 6'h00;
    localparam logic [5:0]        UPD_CFG_RST  = 6'h00;
    localparam logic [6:0]        CLK_CFG_RST  = 7'h00;
    localparam logic [CNT_W-1:0]  INTERVAL_RST = 24'h000014;
    localparam logic [3:0]        CTRL_RST     = 4'h0;

    // timing
    localparam int CLK_KHZ          = 25000;
    localparam int TB_FAST_KHZ      = 20000;
    localparam int TB_SLOW_KHZ      = 100;
    localparam int TRIG_PULSE_MIN_NS = 50;
    localparam int UPD_PULSE_MIN_NS  = 300;
    localparam int TRIG_PULSE_CYC   = (TRIG_PULSE_MIN_NS * CLK_KHZ + 999999) / 1000000;
    localparam int UPD_PULSE_CYC    = (UPD_PULSE_MIN_NS * CLK_KHZ + 999999) / 1000000;
    localparam int PW_W             = 4;

    typedef enum {ST_IDLE, ST_RUN} run_state_e;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_s;

endpackage

//--- logic/pin_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: each bit is an independent level from outside the clock domain
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

//--- tb/wut_props.sv
// Purpose: port checker for waveform_update_timing
// Assumes: one clock domain, ce held high
// Notes:   control bits mirrored from register writes
`timescale 1ns/1ps
module wut_props (
    input wire logic                                clk_sys,
    input wire logic                                nrst,
    input wire logic [wave_timing_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [wave_timing_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                                reg_wr,
    input wire logic                                buf_done,
    input wire logic                                wave_start,
    input wire logic                                wave_running,
    input wire logic                                dac_update,
    input wire wave_timing_pkg::pin_drive_s         trig_mon,
    input wire wave_timing_pkg::pin_drive_s         update_mon_n
);
    logic posted;
    logic gate;
    logic trig_seen;
    logic upd_seen;
    wire  wr_ctrl = reg_wr && reg_addr == wave_timing_pkg::OFF_CTRL;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            posted    <= 1'b0;
            gate      <= 1'b0;
            trig_seen <= 1'b0;
            upd_seen  <= 1'b0;
        end else if (wr_ctrl) begin
            posted    <= reg_wdata[wave_timing_pkg::CTRL_POSTED];
            gate      <= reg_wdata[wave_timing_pkg::CTRL_GATE];
            trig_seen <= trig_seen | reg_wdata[wave_timing_pkg::CTRL_TRIG_OE];
            upd_seen  <= upd_seen | reg_wdata[wave_timing_pkg::CTRL_UPD_OE];
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_start_mon;
        wave_start |-> trig_mon.out && wave_running;
    endproperty
    a_start_mon: assert property (p_start_mon) else $error("start without monitor pulse");
    property p_trig_width;
        $rose(trig_mon.out) |-> trig_mon.out [*2] ##1 !trig_mon.out;
    endproperty
    a_trig_width: assert property (p_trig_width) else $error("trigger monitor width wrong");
    property p_run_start;
        $rose(wave_running) |-> wave_start;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run began without start");
    property p_upd_width;
        $fell(update_mon_n.out) |-> !update_mon_n.out [*8] ##1 update_mon_n.out;
    endproperty
    a_upd_width: assert property (p_upd_width) else $error("strobe monitor width wrong");
    property p_upd_lead;
        $fell(update_mon_n.out) |-> dac_update;
    endproperty
    a_upd_lead: assert property (p_upd_lead) else $error("strobe monitor without update");
    property p_upd_mon;
        dac_update |-> !update_mon_n.out;
    endproperty
    a_upd_mon: assert property (p_upd_mon) else $error("update without strobe monitor");
    property p_gate;
        dac_update |-> $past(posted) && !$past(gate);
    endproperty
    a_gate: assert property (p_gate) else $error("update while gated or not posted");
    property p_trig_oe;
        !trig_seen |-> !trig_mon.oe;
    endproperty
    a_trig_oe: assert property (p_trig_oe) else $error("trigger monitor driven early");
    property p_upd_oe;
        !upd_seen |-> !update_mon_n.oe;
    endproperty
    a_upd_oe: assert property (p_upd_oe) else $error("strobe monitor driven early");
    property p_buf_stop;
        buf_done |=> !wave_running;
    endproperty
    a_buf_stop: assert property (p_buf_stop) else $error("run kept after buffer end");

    c_start: cover property (wave_start);
    c_upd: cover property (dac_update);
    c_buf: cover property (buf_done && wave_running);
endmodule

//--- tb/instrument.sv
// Purpose: external instrument on the function input pins
// Assumes: push-pull pins, no pull resistors
// Notes:   interval clock stands still unless enabled
`timescale 1ns/1ps
module instrument (
    output logic [wave_timing_pkg::PFI_N-1:0] programmable_function_input
);
    logic run_clk = 1'b0;
    int   clk_pin = 0;

    initial programmable_function_input = '0;

    // caller spaces strobe edges for latch reload
    task automatic toggle(input int pin);
        #7 programmable_function_input[pin] = ~programmable_function_input[pin];
    endtask

    // 320 ns period, below the 12.5 MHz ceiling, odd phase
    initial begin
        #13;
        forever begin
            #160;
            if (run_clk)
                programmable_function_input[clk_pin] = ~programmable_function_input[clk_pin];
        end
    end
endmodule

//--- tb/waveform_update_timing_test.sv
// Purpose: self-checking bench for waveform_update_timing
// Assumes: 25 MHz clk_sys, ce held high
// Notes:   pin traffic comes from the instrument model
`timescale 1ns/1ps
module waveform_update_timing_test;
    logic                               clk_sys;
    logic                               nrst;
    logic                               ce;
    logic                               buf_done;
    logic [wave_timing_pkg::ADDR_W-1:0] reg_addr;
    logic [wave_timing_pkg::DATA_W-1:0] reg_wdata;
    logic                               reg_wr;
    logic                               reg_rd;
    logic [wave_timing_pkg::DATA_W-1:0] reg_rdata;
    logic [wave_timing_pkg::PFI_N-1:0]  pfi_in;
    logic                               wave_start;
    logic                               wave_running;
    logic                               dac_update;
    wave_timing_pkg::pin_drive_s        trig_mon;
    wave_timing_pkg::pin_drive_s        update_mon_n;
    logic [31:0]                        rd;
    int                                 miscompares = 0;
    int                                 checked = 0;
    int                                 n;

    instrument u_instrument (.programmable_function_input(pfi_in));
    waveform_update_timing u_waveform_update_timing (.clk_sys, .nrst, .ce, .pfi_in, .buf_done, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wave_start, .wave_running, .dac_update, .trig_mon,
        .update_mon_n);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // cycles until the next converter update
    task automatic gap(input int lim, output int cyc);
        cyc = 0;
        do begin
            @(negedge clk_sys);
            cyc++;
            if (cyc > lim) begin
                check(0, 1);
                finish_test();
            end
        end while (dac_update !== 1'b1);
    endtask

    task automatic quiet(input int cyc);
        repeat (cyc) begin
            @(negedge clk_sys);
            check(dac_update, 1'b0);
        end
    endtask

    task automatic t_regs();
        @(negedge clk_sys);
        check({trig_mon, update_mon_n, wave_running, dac_update}, 6'h08);
        rdr(wave_timing_pkg::OFF_INTERVAL, rd);
        check(rd, 32'h0000_0014);
        wr(wave_timing_pkg::OFF_INTERVAL, 32'hFF00_0030);
        rdr(wave_timing_pkg::OFF_INTERVAL, rd);
        check(rd, 32'h0000_0030);
        wr(8'h20, 32'hFFFF_FFFF);
        rdr(8'h20, rd);
        check(rd, 32'h0000_0000);
    endtask

    task automatic t_trig(input int pin, input logic fall);
        int i;
        wr(wave_timing_pkg::OFF_TRIG_CFG, {fall, pin[3:0]});
        repeat (4) @(posedge clk_sys);
        if (fall) begin
            u_instrument.toggle(pin);
            repeat (4) @(posedge clk_sys);
        end
        u_instrument.toggle(pin);
        for (i = 0; i < 8 && wave_start !== 1'b1; i++)
            @(negedge clk_sys);
        check(wave_start, 1'b1);
        if (wave_start !== 1'b1)
            finish_test();
        @(negedge clk_sys);
        check({wave_start, wave_running}, 2'b01);
        rdr(wave_timing_pkg::OFF_STATUS, rd);
        check(rd[1:0], 2'b11);
        wr(wave_timing_pkg::OFF_CTRL, 32'h100);
        repeat (3) @(negedge clk_sys);
        check(wave_running, 1'b0);
    endtask

    task automatic t_rate(input logic [1:0] src, input logic [31:0] ival, input int exp);
        wr(wave_timing_pkg::OFF_CLK_CFG, {src, 5'h02});
        wr(wave_timing_pkg::OFF_INTERVAL, ival);
        wr(wave_timing_pkg::OFF_CTRL, 32'h20D);
        gap(4 * exp, n);
        gap(2 * exp, n);
        check(n, exp);
        gap(2 * exp, n);
        check(n, exp);
        check({trig_mon.oe, update_mon_n.oe}, 2'b11);
        wr(wave_timing_pkg::OFF_CTRL, 32'h10D);
    endtask

    task automatic t_gate_buf();
        wr(wave_timing_pkg::OFF_CLK_CFG, 32'h0);
        wr(wave_timing_pkg::OFF_INTERVAL, 32'h14);
        wr(wave_timing_pkg::OFF_CTRL, 32'h20F);
        quiet(80);
        wr(wave_timing_pkg::OFF_CTRL, 32'h00D);
        gap(80, n);
        @(posedge clk_sys);
        buf_done <= 1'b1;
        @(posedge clk_sys);
        buf_done <= 1'b0;
        repeat (2) @(negedge clk_sys);
        check(wave_running, 1'b0);
        quiet(80);
    endtask

    task automatic t_ext_upd();
        wr(wave_timing_pkg::OFF_UPD_CFG, 32'h35);
        quiet(3);
        wr(wave_timing_pkg::OFF_CTRL, 32'h200);
        u_instrument.toggle(5);
        quiet(6);
        u_instrument.toggle(5);
        quiet(10);
        wr(wave_timing_pkg::OFF_CTRL, 32'h001);
        rdr(wave_timing_pkg::OFF_STATUS, rd);
        check(rd[1:0], 2'b01);
        u_instrument.toggle(5);
        quiet(6);
        u_instrument.toggle(5);
        gap(6, n);
        wr(wave_timing_pkg::OFF_CTRL, 32'h100);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        nrst      = 1'b0;
        ce        = 1'b1;
        buf_done  = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        t_regs();
        t_trig(3, 1'b0);
        t_trig(7, 1'b1);
        t_rate(wave_timing_pkg::SRC_FAST, 32'h14, 25);
        t_rate(wave_timing_pkg::SRC_SLOW, 32'h2, 500);
        u_instrument.clk_pin = 2;
        u_instrument.run_clk = 1'b1;
        t_rate(wave_timing_pkg::SRC_EXT, 32'h4, 32);
        u_instrument.run_clk = 1'b0;
        t_gate_buf();
        t_ext_upd();
        finish_test();
    end
endmodule

bind waveform_update_timing wut_props u_wut_props (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .buf_done,
    .wave_start, .wave_running, .dac_update, .trig_mon, .update_mon_n);
